/* File: verilog/scm_defines.svh */
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

`define SCM_IDX_CTRL 6'h1b
`define SCM_IDX_MULT 6'h1c
`define SCM_IDX_DIV 6'h1d
`define SCM_IDX_HOLD 6'h1e
`define SCM_IDX_STAT 6'h1f

`define SCM_CTRL_MODE_LSB 0
`define SCM_CTRL_MAXRATE 2
`define SCM_CTRL_OVR1 3
`define SCM_CTRL_WAVE 5
`define SCM_CTRL_FIFOLINE 6
`define SCM_CTRL_MASK 8'h6f
`define SCM_HOLD_FIFO_RST 7
`define SCM_HOLD_W 7

`define SCM_CTRL_RST 8'h02
`define SCM_MODE_RST 2'h2
`define SCM_MULT_RST 8'h00
`define SCM_DIV_RST 8'h00
`define SCM_HOLD_RST 7'h00
`define SCM_FACTOR_RST 9'h001
`define SCM_HOLDOFF_MAX 127

`endif

/* File: verilog/scm_pkg.sv */
package scm_pkg;

    typedef enum logic [1:0] {
        SCM_MODE_OUT_MULT = 2'h0,
        SCM_MODE_ALL_MULT = 2'h1,
        SCM_MODE_OFF = 2'h2,
        SCM_MODE_ALL_NOMULT = 2'h3
    } scm_pll_mode_t;

    typedef enum logic {
        SCM_HOLD_IDLE = 1'b0,
        SCM_HOLD_COUNT = 1'b1
    } scm_hold_state_t;

    typedef struct packed {
        scm_hold_state_t state;
        logic [6:0] count;
    } scm_hold_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mult;
        logic [7:0] div;
        logic [6:0] holdoff;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic firstLoopLock;
        logic maxModulationRate;
        logic [1:0] pllMode;
        logic spreadEnable;
        logic multiplyEnable;
        logic spreadAllClocks;
        logic [8:0] multiplierFactor;
        logic [8:0] dividerFactor;
        logic fifoReset;
        logic waveformReset;
    } scm_state_t;

endpackage

/* File: verilog/scm_ctrl_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

interface scm_ctrl_if;
    logic lineStart;
    logic [`SCM_HOLD_W-1:0] holdoff;
    logic fire;
    logic counting;

    modport ctrl (output lineStart, output holdoff, input fire, input counting);
    modport timer (input lineStart, input holdoff, output fire, output counting);
endinterface

`default_nettype wire

/* File: verilog/scm_line_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module scm_line_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    if (W < 1) begin : g_bad_width
        $error("scm_line_sync: W must be at least 1");
    end

    // stage1 feeds stage2 only; edges are taken from stage2 and stage3
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
endmodule

`default_nettype wire

/* File: verilog/scm_holdoff.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_holdoff
    import scm_pkg::*;
#(
    parameter int HW = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    scm_ctrl_if.timer link
);
    scm_hold_t st;
    scm_hold_t next_st;
    logic fire;

    if (HW != `SCM_HOLD_W) begin : g_bad_width
        $error("scm_holdoff: HW must match the holdoff field");
    end

    always_comb begin
        next_st = st;
        fire = 1'b0;
        if (link.lineStart) begin
            // a new line start always restarts the wait
            if (link.holdoff == 7'h00) begin
                fire = 1'b1;
                next_st.state = SCM_HOLD_IDLE;
            end else begin
                next_st.state = SCM_HOLD_COUNT;
                next_st.count = 7'h01;
            end
        end else begin
            unique case (st.state)
                SCM_HOLD_IDLE: begin
                    next_st.count = 7'h00;
                end
                SCM_HOLD_COUNT: begin
                    // >= so a holdoff lowered mid-wait cannot strand the count
                    if (st.count >= link.holdoff) begin
                        fire = 1'b1;
                        next_st.state = SCM_HOLD_IDLE;
                    end else begin
                        next_st.count = st.count + 7'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.fire = fire;
    assign link.counting = (st.state == SCM_HOLD_COUNT);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_zero_holdoff: assert property (link.lineStart && link.holdoff == 7'h00 |-> fire)
        else $error("zero holdoff did not fire at once");
    a_fire_on_count: assert property (!link.lineStart && st.state == SCM_HOLD_COUNT
        && st.count == link.holdoff |-> fire)
        else $error("holdoff did not fire at programmed count");
    a_no_early_fire: assert property (fire && !link.lineStart |-> st.count >= link.holdoff)
        else $error("holdoff fired early");
    c_long_holdoff: cover property (link.lineStart && link.holdoff == 7'h7f ##1 (!fire)[*8]);
endmodule

`default_nettype wire

/* File: verilog/scm_spread_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

// Overview of operation
// - first loop lock override bit forces lock indication high; clear lets detector through.
// - max rate bit forces fastest modulation instead of line-length-tied rate.
// - two-bit loop mode field resets to loops and spread generator disabled.
// - mode field selects spread-all no-mult, spread-all with mult, outputs-only with mult.
// - multiplied output frequency is input times multiplier over divider.
// - multiplier factor is stored numerator plus one, one through 256.
// - divider factor is stored denominator plus one, one through 256.
// - writing one to fifo reset bit pulses a fifo reset; bit self-clears.
// - seven-bit holdoff delays line-start resets by 0 to 127 cycles.
// - fifo-at-line-start bit resets fifo per line start, else only at spread start or on a manual fifo reset write.
// - waveform-at-line-start bit resets modulation waveform per line start, else never.
module scm_spread_clock_ctrl
    import scm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic lineStartPin,
    input wire logic firstLoopLockRaw,
    output logic firstLoopLock,
    output logic maxModulationRate,
    output logic [1:0] pllMode,
    output logic spreadEnable,
    output logic multiplyEnable,
    output logic spreadAllClocks,
    output logic [8:0] multiplierFactor,
    output logic [8:0] dividerFactor,
    output logic fifoReset,
    output logic waveformReset
);
    scm_state_t st;
    scm_state_t next_st;
    logic [1:0] syncLevel;
    logic [1:0] syncRise;
    logic lockSync;
    logic [5:0] idx;
    logic mapped;
    logic setup;
    logic wrHit;
    logic manualFifo;
    logic spreadStart;
    logic [31:0] rdData;
    logic [7:0] statusByte;

    scm_ctrl_if link ();

    // both come from off-domain logic, so both take two flops first
    scm_line_sync #(
        .W(2)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn({firstLoopLockRaw, lineStartPin}),
        .level(syncLevel),
        .rise(syncRise)
    );

    scm_holdoff #(
        .HW(`SCM_HOLD_W)
    ) u_hold (
        .clock(clock),
        .rst_n(rst_n),
        .link(link.timer)
    );

    assign lockSync = syncLevel[1];
    assign link.lineStart = syncRise[0];
    assign link.holdoff = st.holdoff;

    assign statusByte = {4'h0, syncLevel[0], spreadEnable, link.counting, firstLoopLock};

    always_comb begin
        idx = paddr[7:2];
        setup = psel & ~penable;
        mapped = (idx == `SCM_IDX_CTRL) || (idx == `SCM_IDX_MULT) || (idx == `SCM_IDX_DIV)
            || (idx == `SCM_IDX_HOLD) || (idx == `SCM_IDX_STAT);
        wrHit = psel & penable & st.pready & pwrite;
        manualFifo = wrHit & (idx == `SCM_IDX_HOLD) & pwdata[`SCM_HOLD_FIFO_RST];
        spreadStart = (st.pllMode == SCM_MODE_OFF) && (st.ctrl[1:0] != SCM_MODE_OFF);
        case (idx)
            `SCM_IDX_CTRL: rdData = {24'h00_0000, st.ctrl};
            `SCM_IDX_MULT: rdData = {24'h00_0000, st.mult};
            `SCM_IDX_DIV: rdData = {24'h00_0000, st.div};
            // fifo reset bit always reads back as zero
            `SCM_IDX_HOLD: rdData = {25'h000_0000, st.holdoff};
            `SCM_IDX_STAT: rdData = {24'h00_0000, statusByte};
            default: rdData = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_st = st;
        // zero wait states: ready in the first access cycle
        next_st.pready = setup;
        next_st.pslverr = setup & ~mapped;
        next_st.prdata = (setup & ~pwrite) ? rdData : 32'h0000_0000;

        if (wrHit) begin
            case (idx)
                `SCM_IDX_CTRL: next_st.ctrl = pwdata[7:0] & `SCM_CTRL_MASK;
                `SCM_IDX_MULT: next_st.mult = pwdata[7:0];
                `SCM_IDX_DIV: next_st.div = pwdata[7:0];
                `SCM_IDX_HOLD: next_st.holdoff = pwdata[6:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end

        next_st.firstLoopLock = st.ctrl[`SCM_CTRL_OVR1] | lockSync;
        next_st.maxModulationRate = st.ctrl[`SCM_CTRL_MAXRATE];
        next_st.pllMode = st.ctrl[1:0];

        unique case (scm_pll_mode_t'(st.ctrl[1:0]))
            SCM_MODE_OFF: begin
                next_st.spreadEnable = 1'b0;
                next_st.multiplyEnable = 1'b0;
                next_st.spreadAllClocks = 1'b0;
            end
            SCM_MODE_ALL_NOMULT: begin
                next_st.spreadEnable = 1'b1;
                next_st.multiplyEnable = 1'b0;
                next_st.spreadAllClocks = 1'b1;
            end
            SCM_MODE_ALL_MULT: begin
                next_st.spreadEnable = 1'b1;
                next_st.multiplyEnable = 1'b1;
                next_st.spreadAllClocks = 1'b1;
            end
            SCM_MODE_OUT_MULT: begin
                next_st.spreadEnable = 1'b1;
                next_st.multiplyEnable = 1'b1;
                next_st.spreadAllClocks = 1'b0;
            end
        endcase

        // the loop takes fout = fin * multiplier / divider from these
        next_st.multiplierFactor = {1'b0, st.mult} + 9'h001;
        next_st.dividerFactor = {1'b0, st.div} + 9'h001;

        // one-cycle pulses; spread start always recentres the fifo
        next_st.fifoReset = manualFifo | spreadStart
            | (link.fire & st.ctrl[`SCM_CTRL_FIFOLINE]);
        next_st.waveformReset = link.fire & st.ctrl[`SCM_CTRL_WAVE];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrl <= `SCM_CTRL_RST;
            st.mult <= `SCM_MULT_RST;
            st.div <= `SCM_DIV_RST;
            st.holdoff <= `SCM_HOLD_RST;
            st.pllMode <= `SCM_MODE_RST;
            st.multiplierFactor <= `SCM_FACTOR_RST;
            st.dividerFactor <= `SCM_FACTOR_RST;
        end else begin
            st <= next_st;
        end
    end

    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign prdata = st.prdata;
    assign firstLoopLock = st.firstLoopLock;
    assign maxModulationRate = st.maxModulationRate;
    assign pllMode = st.pllMode;
    assign spreadEnable = st.spreadEnable;
    assign multiplyEnable = st.multiplyEnable;
    assign spreadAllClocks = st.spreadAllClocks;
    assign multiplierFactor = st.multiplierFactor;
    assign dividerFactor = st.dividerFactor;
    assign fifoReset = st.fifoReset;
    assign waveformReset = st.waveformReset;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_lock_forced: assert property (st.ctrl[`SCM_CTRL_OVR1] |=> firstLoopLock)
        else $error("lock not forced by override");
    a_lock_follows: assert property (!st.ctrl[`SCM_CTRL_OVR1] |=> firstLoopLock == $past(lockSync))
        else $error("lock does not follow detector");
    a_max_rate: assert property (##1 maxModulationRate == $past(st.ctrl[`SCM_CTRL_MAXRATE]))
        else $error("max rate output mismatch");
    a_mode_reset: assert property ($past(!rst_n) |-> pllMode == SCM_MODE_OFF && !spreadEnable)
        else $error("mode not disabled after reset");
    a_mode_decode: assert property (spreadEnable == (pllMode != SCM_MODE_OFF)
        && multiplyEnable == (pllMode == SCM_MODE_ALL_MULT || pllMode == SCM_MODE_OUT_MULT))
        else $error("mode decode mismatch");
    a_all_clocks: assert property (spreadAllClocks == (pllMode == SCM_MODE_ALL_MULT
        || pllMode == SCM_MODE_ALL_NOMULT))
        else $error("spread scope decode mismatch");
    a_mult_factor: assert property (##1 multiplierFactor == {1'b0, $past(st.mult)} + 9'h001)
        else $error("multiplier factor wrong");
    a_div_factor: assert property (##1 dividerFactor == {1'b0, $past(st.div)} + 9'h001)
        else $error("divider factor wrong");
    a_factor_range: assert property (multiplierFactor != 9'h000 && dividerFactor != 9'h000)
        else $error("factor out of range");
    a_fifo_manual: assert property (manualFifo |=> fifoReset ##1 !$past(manualFifo))
        else $error("manual fifo reset missing");
    a_fifo_self_clear: assert property (wrHit && idx == `SCM_IDX_HOLD |=> ##1
        (psel && !penable && !pwrite && idx == `SCM_IDX_HOLD) |=> prdata[7] == 1'b0)
        else $error("fifo reset bit did not self clear");
    a_fifo_line: assert property (link.fire && st.ctrl[`SCM_CTRL_FIFOLINE] |=> fifoReset)
        else $error("fifo not reset at line start");
    a_fifo_quiet: assert property (!manualFifo && !spreadStart
        && !(link.fire && st.ctrl[`SCM_CTRL_FIFOLINE]) |=> !fifoReset)
        else $error("spurious fifo reset");
    a_wave_line: assert property (link.fire |=> waveformReset == $past(st.ctrl[`SCM_CTRL_WAVE]))
        else $error("waveform reset gating wrong");
    a_wave_quiet: assert property (!link.fire |=> !waveformReset)
        else $error("waveform reset without line start");
    a_holdoff_zero: assert property (link.lineStart && st.holdoff == 7'h00
        && st.ctrl[`SCM_CTRL_WAVE] |=> waveformReset)
        else $error("zero holdoff did not act next cycle");
    a_holdoff_two: assert property (link.lineStart && st.holdoff == 7'h02
        && st.ctrl[`SCM_CTRL_WAVE] ##1 (!link.lineStart && st.holdoff == 7'h02
        && st.ctrl[`SCM_CTRL_WAVE])[*2] |=> waveformReset)
        else $error("holdoff of two not honoured");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready || (psel && !penable))
        else $error("apb ready timing wrong");

    c_manual_fifo: cover property (manualFifo ##1 fifoReset);
    c_line_wave: cover property (link.lineStart ##[1:130] waveformReset);
    c_spread_start: cover property (spreadStart ##1 fifoReset);
    c_unmapped: cover property (pready && pslverr);
endmodule

`default_nettype wire

/* File: verification/spread_clock_multiplier_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module spread_clock_multiplier_ctrl_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic lineStartPin = 1'b0;
    logic firstLoopLockRaw = 1'b0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic firstLoopLock;
    logic maxModulationRate;
    logic [1:0] pllMode;
    logic spreadEnable;
    logic multiplyEnable;
    logic spreadAllClocks;
    logic [8:0] multiplierFactor;
    logic [8:0] dividerFactor;
    logic fifoReset;
    logic waveformReset;
    logic [31:0] rdata;
    logic rerr;
    int fails = 0;
    int nChecks = 0;

    scm_spread_clock_ctrl dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .lineStartPin(lineStartPin), .firstLoopLockRaw(firstLoopLockRaw),
        .firstLoopLock(firstLoopLock), .maxModulationRate(maxModulationRate), .pllMode(pllMode),
        .spreadEnable(spreadEnable), .multiplyEnable(multiplyEnable),
        .spreadAllClocks(spreadAllClocks), .multiplierFactor(multiplierFactor),
        .dividerFactor(dividerFactor), .fifoReset(fifoReset), .waveformReset(waveformReset)
    );

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // values read right after an edge are the ones that stood before it
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (i == 16) begin
            fails++;
            wrap_up();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
        apb(1'b0, addr, 32'h0000_0000);
        chk(rdata, exp);
        chk(32'(rerr), 32'(expErr));
    endtask

    task automatic t_reset();
        chk(32'(pllMode), 32'h0000_0002);
        chk(32'({spreadEnable, multiplyEnable, spreadAllClocks}), 32'h0000_0000);
        chk(32'(multiplierFactor), 32'h0000_0001);
        chk(32'(dividerFactor), 32'h0000_0001);
        rd_chk(8'h6c, 32'h0000_0002, 1'b0);
        rd_chk(8'h70, 32'h0000_0000, 1'b0);
        rd_chk(8'h74, 32'h0000_0000, 1'b0);
        rd_chk(8'h78, 32'h0000_0000, 1'b0);
        rd_chk(8'h40, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_factors();
        logic [7:0] v [4] = '{8'h00, 8'h01, 8'hff, 8'h7f};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h70, 32'(v[i]));
            apb(1'b1, 8'h74, 32'(~v[i]));
            @(posedge clock);
            chk(32'(multiplierFactor), 32'(v[i]) + 1);
            chk(32'(dividerFactor), 32'(8'(~v[i])) + 1);
            rd_chk(8'h70, 32'(v[i]), 1'b0);
        end
    endtask

    task automatic t_modes();
        // spread, multiply, all-clocks flags per mode code
        logic [2:0] exp [4] = '{3'b110, 3'b111, 3'b000, 3'b101};
        for (int i = 3; i >= 0; i--) begin
            apb(1'b1, 8'h6c, 32'(i) | (32'(i % 2) << 2));
            @(posedge clock);
            chk(32'(pllMode), 32'(i));
            chk(32'({spreadEnable, multiplyEnable, spreadAllClocks}), 32'(exp[i]));
            chk(32'(maxModulationRate), 32'(i % 2));
        end
    endtask

    task automatic t_spread_start();
        int n;
        // mode must leave the off code, so park it there first
        apb(1'b1, 8'h6c, 32'h0000_0002);
        apb(1'b1, 8'h6c, 32'h0000_0000);
        n = 0;
        repeat (5) begin
            if (fifoReset === 1'b1)
                n++;
            @(posedge clock);
        end
        chk(32'(n), 32'h0000_0001);
        apb(1'b1, 8'h6c, 32'h0000_0002);
    endtask

    task automatic t_lock();
        apb(1'b1, 8'h6c, 32'h0000_009a);
        repeat (4) @(posedge clock);
        chk(32'(firstLoopLock), 32'h0000_0001);
        rd_chk(8'h6c, 32'h0000_000a, 1'b0);
        apb(1'b1, 8'h6c, 32'h0000_0002);
        repeat (5) @(posedge clock);
        chk(32'(firstLoopLock), 32'h0000_0000);
        firstLoopLockRaw <= 1'b1;
        repeat (5) @(posedge clock);
        chk(32'(firstLoopLock), 32'h0000_0001);
        firstLoopLockRaw <= 1'b0;
        repeat (5) @(posedge clock);
        chk(32'(firstLoopLock), 32'h0000_0000);
    endtask

    task automatic t_fifo();
        apb(1'b1, 8'h78, 32'h0000_0085);
        chk(32'(fifoReset), 32'h0000_0001);
        @(posedge clock);
        chk(32'(fifoReset), 32'h0000_0000);
        rd_chk(8'h78, 32'h0000_0005, 1'b0);
    endtask

    // pulse lands after sync (2 edges), holdoff and output register (1 edge), read one edge later
    task automatic t_line(input int h, input logic [7:0] ctrl, input logic expW, input logic expF);
        int wN;
        int fN;
        apb(1'b1, 8'h6c, 32'(ctrl));
        apb(1'b1, 8'h78, 32'(h));
        lineStartPin <= 1'b1;
        wN = 0;
        fN = 0;
        for (int n = 1; n <= h + 8; n++) begin
            @(posedge clock);
            if (n == 3)
                lineStartPin <= 1'b0;
            if (waveformReset === 1'b1 && wN == 0)
                wN = n;
            if (fifoReset === 1'b1 && fN == 0)
                fN = n;
        end
        chk(32'(wN), expW ? 32'(h + 4) : 32'h0000_0000);
        chk(32'(fN), expF ? 32'(h + 4) : 32'h0000_0000);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_factors();
        t_modes();
        t_spread_start();
        t_lock();
        t_fifo();
        t_line(0, 8'h22, 1'b1, 1'b0);
        t_line(2, 8'h22, 1'b1, 1'b0);
        t_line(5, 8'h62, 1'b1, 1'b1);
        t_line(127, 8'h62, 1'b1, 1'b1);
        t_line(3, 8'h02, 1'b0, 1'b0);
        wrap_up();
    end

    // whole run is well under 2000 cycles
    initial begin
        #100us;
        fails++;
        wrap_up();
    end
endmodule

`default_nettype wire
